// File: logic/caf_filter_ctrl.sv
// Control register and match steering for acceptance filters ten and eleven.
// Assumes the register master and the receive path share clk; no synchronisers.
`timescale 1ns/1ps
module caf_filter_ctrl
    import caf_pkg::*;
#(
    parameter int IDW  = ID_W,
    parameter int CNTW = CNT_W
) (
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    // Register port
    input  wire logic [ADDR_W-1:0]     addr,
    input  wire logic [DATA_W-1:0]     wdata,
    input  wire logic                  wr,
    input  wire logic                  rd,
    output logic      [DATA_W-1:0]     rdata,
    // Receive path
    input  wire logic                  rxValid,
    input  wire logic [IDW-1:0]        rxId,
    input  wire logic [IDW-1:0]        filterTenId,
    input  wire logic [IDW-1:0]        filterElevenId,
    input  wire logic [IDW-1:0]        maskZero,
    input  wire logic [IDW-1:0]        maskOne,
    input  wire logic [IDW-1:0]        maskTwo,
    input  wire logic [IDW-1:0]        maskThree,
    // Store request towards the FIFO buffers
    output logic                       storeValid,
    output logic      [FIFO_W-1:0]     storeFifo,
    output logic                       storeHitTen,
    output logic                       storeHitEleven
);

    localparam int TEN_LANE    = LANE_LSB + LANE_W * TEN;
    localparam int ELEVEN_LANE = LANE_LSB + LANE_W * ELEVEN;

    logic                      wrCtrl;
    logic                      filterOn  [FILTERS];
    logic [MASK_SEL_W-1:0]     maskPick  [FILTERS];
    logic [FIFO_W-1:0]         fifoPick  [FILTERS];
    logic [IDW-1:0]            filterId  [FILTERS];
    logic [IDW-1:0]            maskBank  [MASKS];
    logic [IDW-1:0]            maskSel   [FILTERS];
    logic                      hit       [FILTERS];
    logic [DATA_W-1:0]         ctrlWord;
    logic [DATA_W-1:0]         statusWord;
    logic                      lastHitTen;
    logic                      lastHitEleven;
    logic [FIFO_W-1:0]         lastFifo;
    logic [CNTW-1:0]           hitCount;
    logic [FIFO_W-1:0]         next_storeFifo;

    // Control word write decode
    assign wrCtrl = wr && (addr == CTRL_ADDR);

    // Per-filter identifiers and the shared mask bank
    assign filterId[TEN]    = filterTenId;
    assign filterId[ELEVEN] = filterElevenId;
    assign maskBank[0]      = maskZero;
    assign maskBank[1]      = maskOne;
    assign maskBank[2]      = maskTwo;
    assign maskBank[3]      = maskThree;

    // Field storage, mask steering and compare, one set per filter
    genvar g;
    generate
        for (g = 0; g < FILTERS; g++) begin : g_filter
            caf_filter_field #(
                .LANE     (LANE_LSB + LANE_W * g)
            ) u_field (
                .clk      (clk),
                .reset_n  (reset_n),
                .wrCtrl   (wrCtrl),
                .wdata    (wdata),
                .filterOn (filterOn[g]),
                .maskPick (maskPick[g]),
                .fifoPick (fifoPick[g])
            );

            // Field value n routes mask n to the compare
            assign maskSel[g] = maskBank[maskPick[g]];

            caf_filter_match #(
                .IDW       (IDW)
            ) u_match (
                .clk       (clk),
                .reset_n   (reset_n),
                .rxValid   (rxValid),
                .rxId      (rxId),
                .filterId  (filterId[g]),
                .maskValue (maskSel[g]),
                .filterOn  (filterOn[g]),
                .hit       (hit[g])
            );
        end
    endgenerate

    // Control word as software reads it; the low half is unimplemented and reads zero
    always_comb begin
        ctrlWord = CTRL_RESET;
        for (int i = 0; i < FILTERS; i++) begin
            ctrlWord[LANE_LSB + LANE_W * i + ON_OFS]                  = filterOn[i];
            ctrlWord[LANE_LSB + LANE_W * i + MASK_OFS +: MASK_SEL_W]  = maskPick[i];
            ctrlWord[LANE_LSB + LANE_W * i + FIFO_OFS +: FIFO_W]      = fifoPick[i];
        end
    end

    // Status word built from the store history
    always_comb begin
        statusWord                                  = '0;
        statusWord[HIT_TEN_BIT]                     = lastHitTen;
        statusWord[HIT_ELEVEN_BIT]                  = lastHitEleven;
        statusWord[LAST_FIFO_LSB +: FIFO_W]         = lastFifo;
        statusWord[COUNT_LSB +: CNTW]               = hitCount;
    end

    // Filter ten wins a double match; one FIFO write per frame keeps the buffers simple
    always_comb begin
        next_storeFifo = FIFO_RESET;
        if (hit[TEN]) begin
            next_storeFifo = fifoPick[TEN];
        end else if (hit[ELEVEN]) begin
            next_storeFifo = fifoPick[ELEVEN];
        end
    end

    // Store request, one cycle after the compare
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            storeValid     <= 1'b0;
            storeFifo      <= FIFO_RESET;
            storeHitTen    <= 1'b0;
            storeHitEleven <= 1'b0;
        end else begin
            storeValid     <= hit[TEN] || hit[ELEVEN];
            storeFifo      <= next_storeFifo;
            storeHitTen    <= hit[TEN];
            storeHitEleven <= hit[ELEVEN];
        end
    end

    // Store history for the status word; the counter wraps
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            lastHitTen    <= 1'b0;
            lastHitEleven <= 1'b0;
            lastFifo      <= FIFO_RESET;
            hitCount      <= '0;
        end else if (hit[TEN] || hit[ELEVEN]) begin
            lastHitTen    <= hit[TEN];
            lastHitEleven <= hit[ELEVEN];
            lastFifo      <= next_storeFifo;
            hitCount      <= hitCount + CNTW'(1);
        end
    end

    // Read data stand for exactly one cycle; unmapped addresses answer zero
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rdata <= '0;
        end else if (rd) begin
            case (addr)
                CTRL_ADDR:   rdata <= ctrlWord;
                STATUS_ADDR: rdata <= statusWord;
                default:     rdata <= '0;
            endcase
        end else begin
            rdata <= '0;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    // Enable bits follow a control write while that filter is off
    property p_eleven_on;
        wrCtrl && !filterOn[ELEVEN] |=> filterOn[ELEVEN] == $past(wdata[ELEVEN_LANE + ON_OFS]);
    endproperty
    a_eleven_on: assert property (p_eleven_on)
        else $error("filter eleven enable did not follow the write");

    property p_ten_on;
        wrCtrl && !filterOn[TEN] |=> filterOn[TEN] == $past(wdata[TEN_LANE + ON_OFS]);
    endproperty
    a_ten_on: assert property (p_ten_on)
        else $error("filter ten enable did not follow the write");

    // Selects load while the filter is off
    property p_eleven_mask;
        wrCtrl && !filterOn[ELEVEN]
        |=> maskPick[ELEVEN] == $past(wdata[ELEVEN_LANE + MASK_OFS +: MASK_SEL_W]);
    endproperty
    a_eleven_mask: assert property (p_eleven_mask)
        else $error("filter eleven mask select not loaded");

    property p_ten_mask;
        wrCtrl && !filterOn[TEN]
        |=> maskPick[TEN] == $past(wdata[TEN_LANE + MASK_OFS +: MASK_SEL_W]);
    endproperty
    a_ten_mask: assert property (p_ten_mask)
        else $error("filter ten mask select not loaded");

    property p_ten_fifo;
        wrCtrl && !filterOn[TEN]
        |=> fifoPick[TEN] == $past(wdata[TEN_LANE + FIFO_OFS +: FIFO_W]);
    endproperty
    a_ten_fifo: assert property (p_ten_fifo)
        else $error("filter ten FIFO select not loaded");

    // A store from filter eleven alone goes to its named buffer
    property p_eleven_store;
        storeValid && storeHitEleven && !storeHitTen
        |-> storeFifo == $past(fifoPick[ELEVEN]);
    endproperty
    a_eleven_store: assert property (p_eleven_store)
        else $error("filter eleven match stored in the wrong buffer");

    // Running filters hold their enable and selects against writes
    property p_lock;
        wrCtrl && filterOn[ELEVEN] && filterOn[TEN]
        |=> $stable(filterOn[ELEVEN]) && $stable(filterOn[TEN])
            && $stable(maskPick[ELEVEN]) && $stable(fifoPick[ELEVEN])
            && $stable(maskPick[TEN]) && $stable(fifoPick[TEN]);
    endproperty
    a_lock: assert property (p_lock)
        else $error("select changed while its filter was on");

    // With both filters off across the pipeline nothing is stored
    property p_off_no_store;
        (!filterOn[TEN] && !filterOn[ELEVEN]) [*3] |-> !storeValid;
    endproperty
    a_off_no_store: assert property (p_off_no_store)
        else $error("store raised while both filters were off");

    // A filter off at receive time never claims the store
    property p_ten_off_no_hit;
        rxValid && !filterOn[TEN] |-> ##2 !storeHitTen;
    endproperty
    a_ten_off_no_hit: assert property (p_ten_off_no_hit)
        else $error("disabled filter ten reported a match");

    // Control readback shows the live fields one cycle after the strobe
    property p_ctrl_read;
        rd && (addr == CTRL_ADDR) |=> rdata == $past(ctrlWord);
    endproperty
    a_ctrl_read: assert property (p_ctrl_read)
        else $error("control readback mismatch");

    // Read data are zero outside the answer cycle
    property p_read_idle;
        !rd |=> rdata == '0;
    endproperty
    a_read_idle: assert property (p_read_idle)
        else $error("read data left standing");

    // Filter eleven FIFO select loads while that filter is off
    property p_eleven_fifo;
        wrCtrl && !filterOn[ELEVEN]
        |=> fifoPick[ELEVEN] == $past(wdata[ELEVEN_LANE + FIFO_OFS +: FIFO_W]);
    endproperty
    a_eleven_fifo: assert property (p_eleven_fifo)
        else $error("filter eleven FIFO select not loaded");

    // Any store claimed by filter ten goes to its buffer, also on a double match
    property p_ten_store;
        storeValid && storeHitTen
        |-> storeFifo == $past(fifoPick[TEN]);
    endproperty
    a_ten_store: assert property (p_ten_store)
        else $error("filter ten match stored in the wrong buffer");

    // Each running filter alone holds its fields against writes
    property p_eleven_lock;
        wrCtrl && filterOn[ELEVEN]
        |=> $stable(filterOn[ELEVEN]) && $stable(maskPick[ELEVEN]) && $stable(fifoPick[ELEVEN]);
    endproperty
    a_eleven_lock: assert property (p_eleven_lock)
        else $error("filter eleven field changed while on");

    property p_ten_lock;
        wrCtrl && filterOn[TEN]
        |=> $stable(filterOn[TEN]) && $stable(maskPick[TEN]) && $stable(fifoPick[TEN]);
    endproperty
    a_ten_lock: assert property (p_ten_lock)
        else $error("filter ten field changed while on");

    // Filter eleven off at receive time never claims the store
    property p_eleven_off_no_hit;
        rxValid && !filterOn[ELEVEN] |-> ##2 !storeHitEleven;
    endproperty
    a_eleven_off_no_hit: assert property (p_eleven_off_no_hit)
        else $error("disabled filter eleven reported a match");

    // Store outputs rest at zero between stores
    property p_store_idle;
        !storeValid |-> storeFifo == '0 && !storeHitTen && !storeHitEleven;
    endproperty
    a_store_idle: assert property (p_store_idle)
        else $error("store outputs active without a store");

    // Status readback shows the store history one cycle after the strobe
    property p_status_read;
        rd && (addr == STATUS_ADDR) |=> rdata == $past(statusWord);
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status readback mismatch");

endmodule : caf_filter_ctrl

// File: pkg/caf_pkg.sv
// Constants shared by the acceptance filter control block for filters ten and eleven.
// Assumes a 32-bit register port and a receive path on the same clock.
package caf_pkg;

    // Register port geometry
    localparam int              ADDR_W      = 8;
    localparam int              DATA_W      = 32;
    localparam logic [7:0]      CTRL_ADDR   = 8'h00;
    localparam logic [7:0]      STATUS_ADDR = 8'h04;
    localparam logic [31:0]     CTRL_RESET  = 32'h00000000;

    // Filter set and field widths
    localparam int              FILTERS     = 2;
    localparam int              TEN         = 0;
    localparam int              ELEVEN      = 1;
    localparam int              ID_W        = 29;
    localparam int              MASKS       = 4;
    localparam int              MASK_SEL_W  = 2;
    localparam int              FIFO_W      = 5;

    // Each filter owns one byte lane; filter ten sits in the lower one
    localparam int              LANE_LSB    = 16;
    localparam int              LANE_W      = 8;
    localparam int              FIFO_OFS    = 0;
    localparam int              MASK_OFS    = 5;
    localparam int              ON_OFS      = 7;

    // Field reset values
    localparam logic            ON_RESET    = 1'h0;
    localparam logic [1:0]      MASK_RESET  = 2'h0;
    localparam logic [4:0]      FIFO_RESET  = 5'h00;

    // Status word layout
    localparam int              HIT_TEN_BIT    = 0;
    localparam int              HIT_ELEVEN_BIT = 1;
    localparam int              LAST_FIFO_LSB  = 8;
    localparam int              COUNT_LSB      = 16;
    localparam int              CNT_W          = 8;

endpackage : caf_pkg

// File: logic/caf_filter_field.sv
// One filter's enable, mask select and FIFO select fields.
// Assumes wrCtrl is a one-cycle strobe for the control word.
`timescale 1ns/1ps
module caf_filter_field
    import caf_pkg::*;
#(
    parameter int LANE = LANE_LSB
) (
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    input  wire logic                  wrCtrl,
    input  wire logic [DATA_W-1:0]     wdata,
    output logic                       filterOn,
    output logic [MASK_SEL_W-1:0]      maskPick,
    output logic [FIFO_W-1:0]          fifoPick
);

    // Enable locks together with the selects; once a filter runs, only reset switches it off
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            filterOn <= ON_RESET;
        end else if (wrCtrl && !filterOn) begin
            filterOn <= wdata[LANE+ON_OFS];
        end
    end

    // Selects freeze while the filter runs, so a live match never sees a torn setting
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            maskPick <= MASK_RESET;
            fifoPick <= FIFO_RESET;
        end else if (wrCtrl && !filterOn) begin
            maskPick <= wdata[LANE+MASK_OFS +: MASK_SEL_W];
            fifoPick <= wdata[LANE+FIFO_OFS +: FIFO_W];
        end
    end

endmodule : caf_filter_field

// File: logic/caf_filter_match.sv
// Masked identifier compare for one filter, result registered.
// Assumes identifier, filter value and mask are stable in the cycle rxValid is high.
`timescale 1ns/1ps
module caf_filter_match
    import caf_pkg::*;
#(
    parameter int IDW = ID_W
) (
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic              rxValid,
    input  wire logic [IDW-1:0]    rxId,
    input  wire logic [IDW-1:0]    filterId,
    input  wire logic [IDW-1:0]    maskValue,
    input  wire logic              filterOn,
    output logic                   hit
);

    // Only bits set in the mask take part in the compare
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            hit <= 1'b0;
        end else begin
            hit <= rxValid && filterOn && (((rxId ^ filterId) & maskValue) == '0);
        end
    end

endmodule : caf_filter_match

// File: dv/caf_filter_ctrl_tb.sv
// Self-checking bench for the filter ten and eleven control block.
// Assumes caf_pkg and the design sources are compiled first; the bench drives every port itself.
`timescale 1ns/1ps
module caf_filter_ctrl_tb;
    import caf_pkg::*;

    logic              clk;
    logic              reset_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
    logic [DATA_W-1:0] rdata;
    logic              rxValid;
    logic [ID_W-1:0]   rxId;
    logic [ID_W-1:0]   tenId;
    logic [ID_W-1:0]   elevenId;
    logic [ID_W-1:0]   masks [MASKS];
    logic              storeValid;
    logic [FIFO_W-1:0] storeFifo;
    logic              hitTen;
    logic              hitEleven;
    logic [31:0]       ctrl;       // Bench copy of the control word
    logic [31:0]       status;     // Bench copy of the status word
    integer            seed;
    int                errorCnt;
    int                checkCount;

    caf_filter_ctrl dut (
        .clk            (clk),
        .reset_n        (reset_n),
        .addr           (addr),
        .wdata          (wdata),
        .wr             (wr),
        .rd             (rd),
        .rdata          (rdata),
        .rxValid        (rxValid),
        .rxId           (rxId),
        .filterTenId    (tenId),
        .filterElevenId (elevenId),
        .maskZero       (masks[0]),
        .maskOne        (masks[1]),
        .maskTwo        (masks[2]),
        .maskThree      (masks[3]),
        .storeValid     (storeValid),
        .storeFifo      (storeFifo),
        .storeHitTen    (hitTen),
        .storeHitEleven (hitEleven)
    );

    // Free-running 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // A filter's enable and selects land only while that filter still reads off
    function automatic logic [31:0] next_ctrl(logic [31:0] cur, logic [31:0] d);
        logic [31:0] n;
        n = cur;
        if (!cur[31]) n[31:24] = d[31:24];
        if (!cur[23]) n[23:16] = d[23:16];
        return n;
    endfunction : next_ctrl

    // Expected {valid, hit eleven, hit ten, fifo}; filter ten wins a double match
    function automatic logic [7:0] exp_store(logic [31:0] c, logic [ID_W-1:0] id);
        logic h10;
        logic h11;
        h10 = c[23] && (((id ^ tenId) & masks[c[22:21]]) == '0);
        h11 = c[31] && (((id ^ elevenId) & masks[c[30:29]]) == '0);
        return {h10 | h11, h11, h10, h10 ? c[20:16] : (h11 ? c[28:24] : 5'h00)};
    endfunction : exp_store

    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            errorCnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr_reg(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        if (a == CTRL_ADDR) ctrl = next_ctrl(ctrl, d);
    endtask : wr_reg

    // Synchronous reset over two edges; the only way to unlock a running filter
    task automatic pulse_reset;
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        ctrl = CTRL_RESET;
        status = '0;
    endtask : pulse_reset

    // Read data stand only in the cycle after the strobe is taken
    task automatic rd_reg(logic [7:0] a, logic [31:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask : rd_reg

    // One frame: outputs one cycle after the taking edge, gone one cycle later
    task automatic rx_frame(logic [ID_W-1:0] id);
        logic [7:0] exp;
        @(posedge clk);
        rxValid <= 1'b1;
        rxId <= id;
        #1;
        exp = exp_store(ctrl, id);
        // Status keeps last flags, last buffer and a wrapping store count
        if (exp[7]) status = {8'h00, 8'(status[23:16] + 8'h01), 3'h0, exp[4:0], 6'h00, exp[6], exp[5]};
        @(posedge clk);
        rxValid <= 1'b0;
        @(posedge clk);
        #1;
        chk({storeValid, hitEleven, hitTen, storeFifo}, exp);
        @(posedge clk);
        #1;
        chk({storeValid, hitEleven, hitTen, storeFifo}, 8'h00);
    endtask : rx_frame

    task automatic finishTest;
        $display("checks %0d mismatches %0d", checkCount, errorCnt);
        if (errorCnt == 0 && checkCount > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finishTest

    // Main sequence
    initial begin
        logic [ID_W-1:0] id;
        logic [ID_W-1:0] pick;
        seed = 32'h39AD;
        errorCnt = 0;
        checkCount = 0;
        ctrl = CTRL_RESET;
        status = '0;
        reset_n = 1'b0;
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
        rxValid = 1'b0;
        rxId = '0;
        tenId = '0;
        elevenId = '0;
        foreach (masks[i]) masks[i] = '0;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        rd_reg(CTRL_ADDR, CTRL_RESET);
        rd_reg(STATUS_ADDR, 32'h00000000);
        $display("test reset done");
        // Every select value with both filters off; low half must read back zero
        for (int i = 0; i < 32; i++) begin
            wr_reg(CTRL_ADDR, {1'b0, i[1:0], i[4:0], 1'b0, ~i[1:0], ~i[4:0], 16'($random(seed))});
            rd_reg(CTRL_ADDR, ctrl);
        end
        $display("test field sweep done");
        // Lock corners: enable and selects frozen while on, reset is the only way out
        wr_reg(CTRL_ADDR, 32'hFFFF0000);
        rd_reg(CTRL_ADDR, ctrl);
        wr_reg(CTRL_ADDR, 32'h80800000);
        rd_reg(CTRL_ADDR, 32'hFFFF0000);
        wr_reg(CTRL_ADDR, 32'h00000000);
        rd_reg(CTRL_ADDR, 32'hFFFF0000);
        pulse_reset();
        wr_reg(CTRL_ADDR, 32'h00800000);
        rd_reg(CTRL_ADDR, ctrl);
        // Status and unmapped places must not disturb the control word
        wr_reg(8'h08, 32'hFFFFFFFF);
        wr_reg(STATUS_ADDR, 32'hFFFFFFFF);
        rd_reg(8'h08, 32'h00000000);
        rd_reg(CTRL_ADDR, ctrl);
        $display("test lock done");
        // Random writes and frames; sparse masks so that forced matches are common
        for (int n = 0; n < 200; n++) begin
            // A reset every fourth frame unlocks both filters for fresh settings
            if (n % 4 == 0) pulse_reset();
            pick = ID_W'($random(seed));
            for (int m = 0; m < MASKS; m++) masks[m] <= ID_W'($random(seed)) & ID_W'($random(seed));
            tenId <= pick;
            elevenId <= (n % 4 == 0) ? pick : ID_W'($random(seed));
            wr_reg(CTRL_ADDR, $random(seed));
            rd_reg(CTRL_ADDR, ctrl);
            case (n % 3)
                0: id = tenId ^ (ID_W'($random(seed)) & ~masks[ctrl[22:21]]);
                1: id = elevenId ^ (ID_W'($random(seed)) & ~masks[ctrl[30:29]]);
                default: id = ID_W'($random(seed));
            endcase
            rx_frame(id);
            rd_reg(STATUS_ADDR, status);
        end
        $display("test random frames done");
        // Reset in mid-run brings both filters back to off and clears the history
        pulse_reset();
        rd_reg(CTRL_ADDR, CTRL_RESET);
        rd_reg(STATUS_ADDR, 32'h00000000);
        rx_frame(tenId);
        $display("test second reset done");
        finishTest();
    end

    // About 2330 cycles are needed; this span leaves ample margin
    initial begin
        #100000;
        errorCnt++;
        finishTest();
    end

endmodule : caf_filter_ctrl_tb
